/* File: rtl/gmr_consts.svh */
// constants for the mac reset sequencing and write pacing block
`ifndef GMR_CONSTS_SVH
`define GMR_CONSTS_SVH

`define GMR_ADDR_W          8
`define GMR_DATA_W          32

`define GMR_OFS_RST_REQ0    8'h00
`define GMR_OFS_RST_REQ1    8'h04
`define GMR_OFS_FLAG_CLR    8'h08
`define GMR_OFS_DMA_MODE    8'h0C
`define GMR_OFS_GP_CTRL     8'h10
`define GMR_OFS_DMA_DEBUG   8'h14
`define GMR_OFS_RXQ_DEBUG   8'h18
`define GMR_OFS_TXQ_DEBUG   8'h1C
`define GMR_OFS_LINK_CFG    8'h20
`define GMR_OFS_LINK_STAT   8'h24

`define GMR_BIT_RST_REQ     0
`define GMR_BIT_RST_FLAG    1
`define GMR_BIT_FLAG_CLR    0
`define GMR_BIT_SOFT_RST    0
`define GMR_BIT_PHY_SEL     0
`define GMR_BIT_PACE_BUSY   3

`define GMR_TX_PS_LSB       4
`define GMR_LINK_CFG_W      16
`define GMR_N_LINK_CLK      3

`define GMR_SR_CYCLES       4
`define GMR_PACE_EDGES      6
`define GMR_ALIVE_CYCLES    64

`endif

/* File: rtl/gmr_pkg.sv */
// types shared by the mac reset sequencing block
`default_nettype none
package gmr_pkg;

    typedef enum logic [1:0] {
        GMR_SR_IDLE = 2'b00,
        GMR_SR_RUN  = 2'b01
    } gmr_sr_e;

    typedef logic [7:0] gmr_addr_t;

endpackage
`default_nettype wire

/* File: rtl/gmr_link_sync.sv */
// link clock samplers: two-flop sync, rising edge strobe, alive watch
`timescale 1ns/100ps
`default_nettype none
`include "gmr_consts.svh"

module gmr_link_sync #(
    parameter int N_CLK       = `GMR_N_LINK_CLK,
    parameter int ALIVE_COUNT = `GMR_ALIVE_CYCLES
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [N_CLK-1:0] i_link_clk,
    output logic      [N_CLK-1:0] o_rise,
    output logic      [N_CLK-1:0] o_alive
);

    genvar g;
    generate
        for (g = 0; g < N_CLK; g = g + 1) begin : g_clk
            logic       meta_q;
            logic       sync_q;
            logic       prev_q;
            logic [6:0] idle_q;

            // meta_q feeds only sync_q
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= i_link_clk[g];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end

            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    o_rise[g] <= 1'b0;
                end else begin
                    o_rise[g] <= sync_q & ~prev_q;
                end
            end

            // a stopped clock is reported so software can see it before reset
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    idle_q     <= 7'h00;
                    o_alive[g] <= 1'b0;
                end else if (sync_q & ~prev_q) begin
                    idle_q     <= 7'h00;
                    o_alive[g] <= 1'b1;
                end else if (idle_q == 7'(ALIVE_COUNT - 1)) begin
                    o_alive[g] <= 1'b0;
                end else begin
                    idle_q <= idle_q + 7'h01;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

/* File: rtl/gmr_pace_xfer.sv */
// paced transfer of one register into the slow link clock domain
`timescale 1ns/100ps
`default_nettype none
`include "gmr_consts.svh"

module gmr_pace_xfer #(
    parameter int W     = `GMR_LINK_CFG_W,
    parameter int N_CLK = `GMR_N_LINK_CLK,
    parameter int EDGES = `GMR_PACE_EDGES
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_flush,
    input  wire logic             i_wr,
    input  wire logic [W-1:0]     i_wdata,
    input  wire logic [N_CLK-1:0] i_rise,
    output logic      [W-1:0]     o_shadow,
    output logic      [W-1:0]     o_dest,
    output logic                  o_busy
);

    logic [N_CLK-1:0] seen_q;
    logic [N_CLK-1:0] seen_all;
    logic             tick;
    logic [3:0]       cnt_q;
    logic [W-1:0]     pend_q;

    // one tick only after every clock has edged: the slowest one sets pace
    assign seen_all = seen_q | i_rise;
    assign tick     = &seen_all;

    always_ff @(posedge i_clk) begin
        if (i_rst || i_flush || !o_busy || tick) begin
            seen_q <= '0;
        end else begin
            seen_q <= seen_all;
        end
    end

    // read back shows the last write until a flush clears it to zero, even one that never lands
    always_ff @(posedge i_clk) begin
        if (i_rst || i_flush) begin
            o_shadow <= '0;
        end else if (i_wr) begin
            o_shadow <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || i_flush) begin
            pend_q <= '0;
            cnt_q  <= 4'h0;
            o_busy <= 1'b0;
            o_dest <= '0;
        end else if (!o_busy) begin
            if (i_wr) begin
                pend_q <= i_wdata;
                cnt_q  <= 4'h0;
                o_busy <= 1'b1;
            end
        end else if (tick) begin
            if (cnt_q == 4'(EDGES - 1)) begin
                o_dest <= pend_q;
                o_busy <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

endmodule
`default_nettype wire

/* File: rtl/gmr_reset_ctrl.sv */
// mac reset sequencing: protected module reset, soft reset, paced config
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "gmr_consts.svh"

module gmr_reset_ctrl #(
    parameter int N_CLK   = `GMR_N_LINK_CLK,
    parameter int CFG_W   = `GMR_LINK_CFG_W,
    parameter int SR_CYC  = `GMR_SR_CYCLES
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic [`GMR_ADDR_W-1:0]  i_addr,
    input  wire logic [`GMR_DATA_W-1:0]  i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic      [`GMR_DATA_W-1:0]  o_rdata,
    input  wire logic                    i_supervisor,
    input  wire logic                    i_wr_protect,
    input  wire logic [N_CLK-1:0]        i_link_clk,
    input  wire logic [3:0]              i_rx_process_state,
    input  wire logic [3:0]              i_tx_process_state,
    input  wire logic [31:0]             i_rx_queue_debug,
    input  wire logic [31:0]             i_tx_queue_debug,
    output logic                         o_module_rst,
    output logic                         o_soft_rst,
    output logic                         o_phy_interface_select,
    output logic      [CFG_W-1:0]        o_link_cfg
);

    logic                   req0_q;
    logic                   req1_q;
    logic                   flag_q;
    logic                   mrst_q;
    logic                   phy_sel_q;
    logic                   soft_bit_q;
    logic [2:0]             sr_cnt_q;
    gmr_pkg::gmr_sr_e       sr_state_q;
    logic [`GMR_DATA_W-1:0] rdata_d;
    logic [`GMR_DATA_W-1:0] rdata_q;
    logic                   wr_ok;
    logic                   wr_req0;
    logic                   wr_req1;
    logic                   wr_clr;
    logic                   wr_dma;
    logic                   wr_gp;
    logic                   wr_cfg;
    logic                   both_req;
    logic                   flush;
    logic [N_CLK-1:0]       rise;
    logic [N_CLK-1:0]       alive;
    logic [CFG_W-1:0]       cfg_shadow;
    logic                   pace_busy;

    // protected registers ignore the write silently, no error is raised
    assign wr_ok   = i_supervisor & ~i_wr_protect;
    assign wr_req0 = i_wr & wr_ok & (i_addr == `GMR_OFS_RST_REQ0);
    assign wr_req1 = i_wr & wr_ok & (i_addr == `GMR_OFS_RST_REQ1);
    assign wr_clr  = i_wr & wr_ok & (i_addr == `GMR_OFS_FLAG_CLR)
                   & i_wdata[`GMR_BIT_FLAG_CLR];
    assign wr_dma  = i_wr & (i_addr == `GMR_OFS_DMA_MODE);
    assign wr_gp   = i_wr & (i_addr == `GMR_OFS_GP_CTRL);
    assign wr_cfg  = i_wr & (i_addr == `GMR_OFS_LINK_CFG);

    assign both_req = req0_q & req1_q;

    // module reset and soft reset both wipe the link-facing config
    assign flush = mrst_q | soft_bit_q;

    // request bits wait for their partner, then fire together
    always_ff @(posedge i_clk) begin
        if (i_rst || both_req) begin
            req0_q <= 1'b0;
            req1_q <= 1'b0;
        end else begin
            if (wr_req0 && i_wdata[`GMR_BIT_RST_REQ]) begin
                req0_q <= 1'b1;
            end
            if (wr_req1 && i_wdata[`GMR_BIT_RST_REQ]) begin
                req1_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mrst_q <= 1'b0;
        end else begin
            mrst_q <= both_req;
        end
    end

    // the flag survives the module reset it reports; set beats clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flag_q <= 1'b0;
        end else if (mrst_q) begin
            flag_q <= 1'b1;
        end else if (wr_clr) begin
            flag_q <= 1'b0;
        end
    end

    // interface select goes back to mii on module reset, so it must be
    // programmed again before the soft reset
    always_ff @(posedge i_clk) begin
        if (i_rst || mrst_q) begin
            phy_sel_q <= 1'b0;
        end else if (wr_gp) begin
            phy_sel_q <= i_wdata[`GMR_BIT_PHY_SEL];
        end
    end

    // soft reset: bit reads one for three cycles, zero on the fourth
    always_ff @(posedge i_clk) begin
        if (i_rst || mrst_q) begin
            sr_state_q <= gmr_pkg::GMR_SR_IDLE;
            soft_bit_q <= 1'b0;
            sr_cnt_q   <= 3'h0;
        end else if (wr_dma && i_wdata[`GMR_BIT_SOFT_RST]) begin
            sr_state_q <= gmr_pkg::GMR_SR_RUN;
            soft_bit_q <= 1'b1;
            sr_cnt_q   <= 3'(SR_CYC - 2);
        end else begin
            case (sr_state_q)
                gmr_pkg::GMR_SR_IDLE: begin
                    soft_bit_q <= 1'b0;
                end
                gmr_pkg::GMR_SR_RUN: begin
                    if (sr_cnt_q == 3'h0) begin
                        sr_state_q <= gmr_pkg::GMR_SR_IDLE;
                        soft_bit_q <= 1'b0;
                    end else begin
                        sr_cnt_q <= sr_cnt_q - 3'h1;
                    end
                end
                default: begin
                    sr_state_q <= gmr_pkg::GMR_SR_IDLE;
                    soft_bit_q <= 1'b0;
                end
            endcase
        end
    end

    gmr_link_sync #(
        .N_CLK       (N_CLK),
        .ALIVE_COUNT (`GMR_ALIVE_CYCLES)
    ) u_sync (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_link_clk (i_link_clk),
        .o_rise     (rise),
        .o_alive    (alive)
    );

    gmr_pace_xfer #(
        .W     (CFG_W),
        .N_CLK (N_CLK),
        .EDGES (`GMR_PACE_EDGES)
    ) u_pace (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_flush  (flush),
        .i_wr     (wr_cfg),
        .i_wdata  (i_wdata[CFG_W-1:0]),
        .i_rise   (rise),
        .o_shadow (cfg_shadow),
        .o_dest   (o_link_cfg),
        .o_busy   (pace_busy)
    );

    // status words let software check stopped processes and empty queues
    always_comb begin
        rdata_d = '0;
        case (i_addr)
            `GMR_OFS_RST_REQ0: begin
                rdata_d[`GMR_BIT_RST_REQ]  = req0_q;
                rdata_d[`GMR_BIT_RST_FLAG] = flag_q;
            end
            `GMR_OFS_RST_REQ1: begin
                rdata_d[`GMR_BIT_RST_REQ] = req1_q;
            end
            `GMR_OFS_DMA_MODE: begin
                rdata_d[`GMR_BIT_SOFT_RST] = soft_bit_q;
            end
            `GMR_OFS_GP_CTRL: begin
                rdata_d[`GMR_BIT_PHY_SEL] = phy_sel_q;
            end
            `GMR_OFS_DMA_DEBUG: begin
                rdata_d[3:0] = i_rx_process_state;
                rdata_d[`GMR_TX_PS_LSB+3:`GMR_TX_PS_LSB] = i_tx_process_state;
            end
            `GMR_OFS_RXQ_DEBUG: begin
                rdata_d = i_rx_queue_debug;
            end
            `GMR_OFS_TXQ_DEBUG: begin
                rdata_d = i_tx_queue_debug;
            end
            `GMR_OFS_LINK_CFG: begin
                rdata_d[CFG_W-1:0] = cfg_shadow;
            end
            `GMR_OFS_LINK_STAT: begin
                rdata_d[N_CLK-1:0]          = alive;
                rdata_d[`GMR_BIT_PACE_BUSY] = pace_busy;
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_rd) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata                = rdata_q;
    assign o_module_rst           = mrst_q;
    assign o_soft_rst             = soft_bit_q;
    assign o_phy_interface_select = phy_sel_q;

endmodule
`default_nettype wire

/* File: dv/gmr_reset_ctrl_sva.sv */
// port assertions for the mac reset sequencing block
`timescale 1ns/100ps
`default_nettype none
module gmr_reset_ctrl_sva #(
    parameter int N_CLK   = 3,
    parameter int CFG_W   = 16,
    parameter int SR_CYC  = 4
) (
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic [7:0]       i_addr,
    input wire logic [31:0]      i_wdata,
    input wire logic             i_wr,
    input wire logic             i_supervisor,
    input wire logic             i_wr_protect,
    input wire logic             o_module_rst,
    input wire logic             o_soft_rst,
    input wire logic             o_phy_interface_select,
    input wire logic [CFG_W-1:0] o_link_cfg
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence soft_req;
        i_wr && i_addr == 8'h0C && i_wdata[0];
    endsequence
    sequence soft_run;
        o_soft_rst [*3] ##1 !o_soft_rst;
    endsequence
    soft_len_a: assert property (soft_req |=> soft_run)
        else $error("soft reset length wrong");
    soft_cause_a: assert property ($rose(o_soft_rst) |->
        $past(i_wr && i_addr == 8'h0C && i_wdata[0]))
        else $error("soft reset without write");
    mrst_pulse_a: assert property (o_module_rst |=> !o_module_rst)
        else $error("module reset pulse too long");
    mrst_gate_a: assert property (o_module_rst |-> $past(i_wr
        && i_wdata[0] && i_supervisor && !i_wr_protect
        && (i_addr == 8'h00 || i_addr == 8'h04), 2))
        else $error("module reset without permitted request");
    mrst_clear_a: assert property (o_module_rst |=> !o_soft_rst
        && !o_phy_interface_select && o_link_cfg == '0)
        else $error("module reset left state");
    phy_sel_a: assert property (i_wr && i_addr == 8'h10
        && !o_module_rst |=> o_phy_interface_select == $past(i_wdata[0]))
        else $error("interface select not written");
    cfg_hold_a: assert property (i_wr && i_addr == 8'h20
        |=> $stable(o_link_cfg) [*8])
        else $error("link config changed too early");
    cfg_flush_a: assert property (soft_req
        |-> ##[1:4] o_link_cfg == '0)
        else $error("soft reset kept link config");
endmodule
`default_nettype wire

/* File: dv/gmr_phy_model.sv */
// phy side model: link clocks, each one can be stopped
`timescale 1ns/100ps
`default_nettype none
module gmr_phy_model #(
    parameter int HALF_NS = 32
) (
    input  wire logic [2:0] i_run,
    output logic      [2:0] o_link_clk
);
    // staggered start so no two clocks share an edge with the bench clock
    for (genvar k = 0; k < 3; k++) begin : g_clk
        initial begin
            o_link_clk[k] = 1'b0;
            #(7 * k + 3);
            forever begin
                #(HALF_NS);
                if (i_run[k]) begin
                    o_link_clk[k] = ~o_link_clk[k];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb_gmr_reset_ctrl.sv */
// self-checking bench for the mac reset sequencing block
`timescale 1ns/100ps
`default_nettype none
module tb_gmr_reset_ctrl;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_supervisor = 1'b0;
    logic        i_wr_protect = 1'b1;
    logic [3:0]  rx_ps = 4'h0;
    logic [3:0]  tx_ps = 4'h0;
    logic [31:0] rxq_dbg = 32'h0;
    logic [31:0] txq_dbg = 32'h0;
    logic [2:0]  run = 3'h7;
    wire logic [2:0]  link_clk;
    wire logic [31:0] rdata;
    wire logic        module_rst;
    wire logic        soft_rst;
    wire logic        phy_sel;
    wire logic [15:0] link_cfg;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_mrst = 0;
    always #4 i_clk = ~i_clk;
    gmr_phy_model i_phy (.i_run(run), .o_link_clk(link_clk));
    gmr_reset_ctrl i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_supervisor(i_supervisor), .i_wr_protect(i_wr_protect),
        .i_link_clk(link_clk), .i_rx_process_state(rx_ps),
        .i_tx_process_state(tx_ps), .i_rx_queue_debug(rxq_dbg),
        .i_tx_queue_debug(txq_dbg), .o_module_rst(module_rst),
        .o_soft_rst(soft_rst), .o_phy_interface_select(phy_sel),
        .o_link_cfg(link_cfg));
    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (module_rst === 1'b1) begin
            n_mrst++;
        end
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge i_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    // polls the pacing busy bit with a bounded number of reads
    task automatic wait_idle;
        logic [31:0] d;
        int k;
        d = 32'h8;
        for (k = 0; k < 200 && d[3] !== 1'b0; k++) begin
            rd(8'h24, d);
        end
        chk({31'h0, d[3]}, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rdc(8'h00, 32'h0);
        rdc(8'h20, 32'h0);
        rdc(8'h30, 32'h0);
        rx_ps <= 4'h3;
        tx_ps <= 4'h6;
        rxq_dbg <= 32'h0000_0A50;
        txq_dbg <= 32'h0001_0003;
        rdc(8'h14, 32'h63);
        rdc(8'h18, 32'h0000_0A50);
        rdc(8'h1C, 32'h0001_0003);
        rx_ps <= 4'h0;
        tx_ps <= 4'h0;
        rxq_dbg <= 32'h0;
        txq_dbg <= 32'h0;
        rdc(8'h14, 32'h0);
        wr(8'h10, 32'h1);
        wr(8'h00, 32'h1);
        rdc(8'h00, 32'h0);
        i_supervisor <= 1'b1;
        wr(8'h00, 32'h1);
        rdc(8'h00, 32'h0);
        i_supervisor <= 1'b0;
        i_wr_protect <= 1'b0;
        wr(8'h04, 32'h1);
        rdc(8'h04, 32'h0);
        i_supervisor <= 1'b1;
        wr(8'h00, 32'h1);
        rdc(8'h00, 32'h1);
        chk(n_mrst, 0);
        wr(8'h04, 32'h1);
        i_wr_protect <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk(n_mrst, 1);
        chk({31'h0, phy_sel}, 32'h0);
        rdc(8'h00, 32'h2);
        wr(8'h08, 32'h1);
        rdc(8'h00, 32'h2);
        i_wr_protect <= 1'b0;
        wr(8'h08, 32'h1);
        rdc(8'h00, 32'h0);
        i_wr_protect <= 1'b1;
        repeat (70) @(posedge i_clk);
        rdc(8'h18, 32'h0);
        wr(8'h10, 32'h1);
        chk({31'h0, phy_sel}, 32'h1);
        wr(8'h0C, 32'h1);
        rdc(8'h0C, 32'h1);
        rdc(8'h0C, 32'h0);
        chk({31'h0, soft_rst}, 32'h0);
        wr(8'h20, 32'h1234);
        rdc(8'h24, 32'hF);
        wr(8'h20, 32'h5678);
        rdc(8'h20, 32'h5678);
        wait_idle();
        chk({16'h0, link_cfg}, 32'h1234);
        wr(8'h20, 32'hABCD);
        wait_idle();
        chk({16'h0, link_cfg}, 32'hABCD);
        run <= 3'b011;
        repeat (80) @(posedge i_clk);
        wr(8'h20, 32'h0F0F);
        repeat (100) @(posedge i_clk);
        rdc(8'h24, 32'hB);
        chk({16'h0, link_cfg}, 32'hABCD);
        run <= 3'b111;
        wait_idle();
        chk({16'h0, link_cfg}, 32'h0F0F);
        wr(8'h0C, 32'h1);
        repeat (5) @(posedge i_clk);
        chk({16'h0, link_cfg}, 32'h0);
        report_and_stop();
    end
endmodule
bind gmr_reset_ctrl gmr_reset_ctrl_sva #(
    .N_CLK(N_CLK), .CFG_W(CFG_W), .SR_CYC(SR_CYC)
) i_sva (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_supervisor(i_supervisor), .i_wr_protect(i_wr_protect),
    .o_module_rst(o_module_rst), .o_soft_rst(o_soft_rst),
    .o_phy_interface_select(o_phy_interface_select),
    .o_link_cfg(o_link_cfg));
`default_nettype wire
